// ---- common/scc_pkg.sv ----
// Purpose: shared constants and types for the sensor channel config bank
// Assumes: 8-bit registers in the low byte of a 32-bit apb word
// Notes:   printed offsets are not all multiples of four, so they are indices
package scc_pkg;

  localparam int unsigned NUM_CH = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_COUNTER_SCALE = 8'h1E;
  localparam logic [7:0] IDX_CH0_SENSOR    = 8'h20;
  localparam logic [7:0] IDX_CH1_SENSOR    = 8'h22;
  localparam logic [7:0] IDX_CH2_SENSOR    = 8'h24;
  localparam logic [7:0] IDX_CH0_TRACKING  = 8'h25;
  localparam logic [7:0] IDX_CH3_SENSOR    = 8'h26;
  localparam logic [7:0] IDX_WINDOW_CTRL   = 8'h30;
  localparam logic [7:0] IDX_ACTIVE_STATUS = 8'h31;

  // field positions
  localparam int unsigned CSC_W       = 2;
  localparam int unsigned RP_BIT      = 7;
  localparam int unsigned FREQ_LSB    = 5;
  localparam int unsigned CYC_LSB     = 0;
  localparam int unsigned CYC_W       = 5;
  localparam int unsigned FTF_LSB     = 1;
  localparam int unsigned WINDOW_DIVIDER_EXPONENT_W     = 3;

  // reset values
  localparam logic [1:0] CSC_RST      = 2'h1;
  localparam logic       RP_RST       = 1'h0;
  localparam logic [1:0] FREQ_RST     = 2'h0;
  localparam logic [4:0] CYC_RST      = 5'h04;
  localparam logic [1:0] FTF_RST      = 2'h1;
  localparam logic [2:0] WINDOW_DIVIDER_EXPONENT_RST    = 3'h0;

  typedef enum logic [1:0] {
    SCC_FREQ_LOW  = 2'h0,
    SCC_FREQ_MID  = 2'h1,
    SCC_FREQ_HIGH = 2'h2,
    SCC_FREQ_RSVD = 2'h3
  } scc_freq_e;

  typedef struct packed {
    logic [1:0] counter_scale;
    logic       resistance_range;
    scc_freq_e  frequency_range;
    logic [4:0] cycle_count;
  } scc_chan_cfg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scc_apb_req_s;

endpackage : scc_pkg

// ---- logic/scc_window_latch.sv ----
// Purpose: per-channel shadow of configuration, applied at window start
// Assumes: window_start is a one-cycle pulse from the conversion core
// Notes:   avoids a conversion running with half-old, half-new settings
`timescale 1ns/1ps
module scc_window_latch
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  window_start,
  input  wire scc_pkg::scc_chan_cfg_s staged,
  output scc_pkg::scc_chan_cfg_s     applied
);

  localparam scc_pkg::scc_chan_cfg_s CFG_RST =
    '{scc_pkg::CSC_RST, scc_pkg::RP_RST, scc_pkg::SCC_FREQ_LOW, scc_pkg::CYC_RST};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      applied <= CFG_RST;
    else if (window_start)
      applied <= staged;
  end

  property p_hold_between;
    @(posedge pclk) disable iff (!presetn)
    !window_start |=> applied == $past(applied);
  endproperty
  a_hold_between : assert property (p_hold_between)
    else $error("applied config changed outside a window start");

  property p_take_at_start;
    @(posedge pclk) disable iff (!presetn)
    window_start |=> applied == $past(staged);
  endproperty
  a_take_at_start : assert property (p_take_at_start)
    else $error("applied config not taken at window start");

endmodule // scc_window_latch

// ---- logic/scc_regs.sv ----
// Purpose: apb register bank holding per-channel sensing configuration
// Assumes: single clock, zero-wait apb slave, byte address = 4 * index
// Notes:   channels 2 and 3 only act when FOUR_CH is set
`timescale 1ns/1ps

// Summary of operation
// - two-bit counter scale per channel, ch3 at 7:6 to ch0 at 1:0, reset 1.
// - bit 7 of sensor config selects resistance range, reset 0.
// - bits 6:5 select frequency range; 00 at reset, 01 and 10 higher.
// - bits 4:0 hold the cycle count, reset 00100, sets window length.
// - channel 0 fast tracking factor in bits 2:1, reset 1.
// - channels 2 and 3 are functional only in the four-channel variant.
module scc_regs
#(
  parameter bit FOUR_CH = 1'b1
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire scc_pkg::scc_apb_req_s  apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [3:0]             window_start,
  output scc_pkg::scc_chan_cfg_s [3:0] chan_cfg,
  output logic [3:0]                  chan_enable,
  output logic [2:0]                  window_divider_exponent,
  output logic [1:0]                  ch0_fast_track_factor
);

  logic [7:0]  counter_scale_cfg;
  logic [7:0]  sensor_cfg [4];
  logic [1:0]  ch0_tracking;
  logic [2:0]  window_ctrl;

  function automatic logic [7:0] word_index(input logic [11:0] a);
    return a[9:2];
  endfunction

  wire         access     = apb_req.psel && apb_req.penable;
  wire         wr_en      = access && apb_req.pwrite;
  wire  [7:0]  idx        = word_index(apb_req.paddr);
  wire         aligned    = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr[11:10] == 2'h0;
  wire  [3:0]  ch_present = FOUR_CH ? 4'hF : 4'h3;

  wire hit_csc  = aligned && idx == scc_pkg::IDX_COUNTER_SCALE;
  wire hit_ftf  = aligned && idx == scc_pkg::IDX_CH0_TRACKING;
  wire hit_win  = aligned && idx == scc_pkg::IDX_WINDOW_CTRL;
  wire hit_stat = aligned && idx == scc_pkg::IDX_ACTIVE_STATUS;
  wire [3:0] hit_sen;
  assign hit_sen[0] = aligned && idx == scc_pkg::IDX_CH0_SENSOR;
  assign hit_sen[1] = aligned && idx == scc_pkg::IDX_CH1_SENSOR;
  assign hit_sen[2] = aligned && idx == scc_pkg::IDX_CH2_SENSOR;
  assign hit_sen[3] = aligned && idx == scc_pkg::IDX_CH3_SENSOR;
  wire mapped = hit_csc || hit_ftf || hit_win || hit_stat || (|hit_sen);

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  localparam logic [7:0] CSC_WORD_RST = {4{scc_pkg::CSC_RST}};
  localparam logic [7:0] SEN_WORD_RST = {scc_pkg::RP_RST, scc_pkg::FREQ_RST, scc_pkg::CYC_RST};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter_scale_cfg <= CSC_WORD_RST;
    else if (wr_en && hit_csc)
      counter_scale_cfg <= apb_req.pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch0_tracking <= scc_pkg::FTF_RST;
      window_ctrl  <= scc_pkg::WINDOW_DIVIDER_EXPONENT_RST;
    end
    else
    begin
      // reserved tracking bits are not stored and read back as zero
      if (wr_en && hit_ftf)
        ch0_tracking <= apb_req.pwdata[scc_pkg::FTF_LSB +: 2];
      if (wr_en && hit_win)
        window_ctrl <= apb_req.pwdata[scc_pkg::WINDOW_DIVIDER_EXPONENT_W-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < scc_pkg::NUM_CH; g++)
    begin : g_ch
      scc_pkg::scc_chan_cfg_s staged;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          sensor_cfg[g] <= SEN_WORD_RST;
        else if (wr_en && hit_sen[g])
          sensor_cfg[g] <= apb_req.pwdata[7:0];
      end

      assign staged.counter_scale    = counter_scale_cfg[g*scc_pkg::CSC_W +: 2];
      assign staged.resistance_range = sensor_cfg[g][scc_pkg::RP_BIT];
      assign staged.frequency_range  =
        scc_pkg::scc_freq_e'(sensor_cfg[g][scc_pkg::FREQ_LSB +: 2]);
      assign staged.cycle_count      = sensor_cfg[g][scc_pkg::CYC_LSB +: scc_pkg::CYC_W];

      // absent channels never see a window start, so keep reset values
      scc_window_latch u_latch
      (
        .pclk         (pclk),
        .presetn      (presetn),
        .window_start (window_start[g] && ch_present[g]),
        .staged       (staged),
        .applied      (chan_cfg[g])
      );
    end
  endgenerate

  assign chan_enable             = ch_present;
  assign window_divider_exponent = window_ctrl;

  logic [7:0] read_byte;
  always_comb
  begin
    read_byte = 8'h00;
    if (hit_csc)
      read_byte = counter_scale_cfg;
    else if (hit_sen[0])
      read_byte = sensor_cfg[0];
    else if (hit_sen[1])
      read_byte = sensor_cfg[1];
    else if (hit_sen[2])
      read_byte = sensor_cfg[2];
    else if (hit_sen[3])
      read_byte = sensor_cfg[3];
    else if (hit_ftf)
      read_byte = {5'h00, ch0_tracking, 1'b0};
    else if (hit_win)
      read_byte = {5'h00, window_ctrl};
    else if (hit_stat)
      read_byte = {4'h0, ch_present};
  end

  // data output from a flop, loaded during the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      prdata <= {24'h00_0000, read_byte};
  end

  // ftf output follows tracking register; algorithm samples it per window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch0_fast_track_factor <= scc_pkg::FTF_RST;
    else
      ch0_fast_track_factor <= ch0_tracking;
  end

  property p_csc_write;
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit_csc |=> counter_scale_cfg == $past(apb_req.pwdata[7:0]);
  endproperty
  a_csc_write : assert property (p_csc_write)
    else $error("counter scale write not stored");

  property p_sen_write;
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit_sen[0] |=> sensor_cfg[0] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_sen_write : assert property (p_sen_write)
    else $error("sensor config write not stored");

  property p_ftf_read;
    @(posedge pclk) disable iff (!presetn)
    hit_ftf |-> read_byte[7:3] == 5'h00 && read_byte[0] == 1'b0;
  endproperty
  a_ftf_read : assert property (p_ftf_read)
    else $error("tracking reserved bits not zero");

  // write lands in the register first, the output follows a cycle later
  sequence s_ftf_write;
    wr_en && hit_ftf;
  endsequence

  property p_ftf_out;
    @(posedge pclk) disable iff (!presetn)
    s_ftf_write |=> ##1
      ch0_fast_track_factor == $past(apb_req.pwdata[scc_pkg::FTF_LSB +: 2], 2);
  endproperty
  a_ftf_out : assert property (p_ftf_out)
    else $error("fast track factor not applied");

  property p_absent_ch;
    @(posedge pclk) disable iff (!presetn)
    !FOUR_CH |-> chan_cfg[2].cycle_count == scc_pkg::CYC_RST
                 && chan_cfg[3].frequency_range == scc_pkg::SCC_FREQ_LOW;
  endproperty
  a_absent_ch : assert property (p_absent_ch)
    else $error("absent channel configuration changed");

  property p_rp_map;
    @(posedge pclk) disable iff (!presetn)
    window_start[1] |=> chan_cfg[1].resistance_range == $past(sensor_cfg[1][7]);
  endproperty
  a_rp_map : assert property (p_rp_map)
    else $error("resistance range not mapped from bit 7");

  property p_freq_map;
    @(posedge pclk) disable iff (!presetn)
    window_start[0] |=> chan_cfg[0].frequency_range == $past(sensor_cfg[0][6:5]);
  endproperty
  a_freq_map : assert property (p_freq_map)
    else $error("frequency range not mapped from bits 6:5");

  property p_csc_map;
    @(posedge pclk) disable iff (!presetn)
    window_start[1] |=> chan_cfg[1].counter_scale == $past(counter_scale_cfg[3:2]);
  endproperty
  a_csc_map : assert property (p_csc_map)
    else $error("counter scale field misplaced");

  // an access outside the map is flagged and must leave the scale, ch0 sensor, tracking and window registers alone
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    access && !mapped |-> pslverr ##1 (counter_scale_cfg == $past(counter_scale_cfg)
                                       && sensor_cfg[0] == $past(sensor_cfg[0])
                                       && ch0_tracking == $past(ch0_tracking)
                                       && window_ctrl == $past(window_ctrl));
  endproperty
  a_unmapped : assert property (p_unmapped)
    else $error("unmapped access flagged wrongly or changed a register");

  property p_win_write;
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit_win |=>
      window_divider_exponent == $past(apb_req.pwdata[scc_pkg::WINDOW_DIVIDER_EXPONENT_W-1:0]);
  endproperty
  a_win_write : assert property (p_win_write)
    else $error("divider exponent write not applied");

endmodule // scc_regs

// ---- dv/scc_regs_test.sv ----
// Purpose: self-checking bench for the sensor channel config register bank
// Assumes: both variants on one bus, byte address = 4 * index
// Notes:   window pulses are driven by the bench in place of the conversion core
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module scc_regs_test;
  logic                         pclk = 1'b0;
  logic                         presetn = 1'b0;
  scc_pkg::scc_apb_req_s        req = '0;
  logic [3:0]                   ws = 4'h0;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  scc_pkg::scc_chan_cfg_s [3:0] chan_cfg;
  logic [3:0]                   chan_enable;
  scc_pkg::scc_chan_cfg_s [3:0] chan_cfg2;
  logic [3:0]                   chan_enable2;
  logic [2:0]                   div_exp;
  logic [1:0]                   ftf;
  int                           miscompares = 0;
  int                           total_checks = 0;
  int                           cycles = 0;
  logic [31:0]                  rd;
  logic                         err;
  logic [7:0]                   v;
  localparam logic [7:0] SIDX [4] = '{scc_pkg::IDX_CH0_SENSOR, scc_pkg::IDX_CH1_SENSOR,
                                      scc_pkg::IDX_CH2_SENSOR, scc_pkg::IDX_CH3_SENSOR};

  scc_regs #(.FOUR_CH(1'b1)) dut (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .apb_req                 (req),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .window_start            (ws),
    .chan_cfg                (chan_cfg),
    .chan_enable             (chan_enable),
    .window_divider_exponent (div_exp),
    .ch0_fast_track_factor   (ftf)
  );

  // two-channel variant sees the same bus and window pulses
  scc_regs #(.FOUR_CH(1'b0)) dut_two (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .apb_req                 (req),
    .prdata                  (),
    .pready                  (),
    .pslverr                 (),
    .window_start            (ws),
    .chan_cfg                (chan_cfg2),
    .chan_enable             (chan_enable2),
    .window_divider_exponent (),
    .ch0_fast_track_factor   ()
  );

  initial
  begin
    forever #4 pclk = ~pclk;
  end

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // one transfer: setup, access held until pready seen high at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ba(idx), pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge pclk);
    ws <= m;
    @(posedge pclk);
    ws <= 4'h0;
    #1;
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    for (int n = 0; n < 4; n++)
      `CHK("cfg_rst", {2'h1, 8'h04}, chan_cfg[n])
    `CHK("ftf_rst", 2'h1, ftf)
    `CHK("present", 4'hF, chan_enable)
    `CHK("present2", 4'h3, chan_enable2)
    `CHK("div_rst", 3'h0, div_exp)
    apb(1'b0, scc_pkg::IDX_COUNTER_SCALE, 32'h0);
    `CHK("cs_rst", 32'h00000055, rd)
    for (int n = 0; n < 4; n++)
    begin
      apb(1'b0, SIDX[n], 32'h0);
      `CHK("sens_rst", 32'h00000004, rd)
    end
    apb(1'b0, scc_pkg::IDX_CH0_TRACKING, 32'h0);
    `CHK("trk_rst", 32'h00000002, rd)
    // distinct scale per channel so a lane swap shows
    apb(1'b1, scc_pkg::IDX_COUNTER_SCALE, 32'h000000E4);
    apb(1'b0, scc_pkg::IDX_COUNTER_SCALE, 32'h0);
    `CHK("cs_rw", 32'h000000E4, rd)
    // frequency codes 0..2 only; code 3 stays unused
    for (int n = 0; n < 4; n++)
    begin
      v = {n[0], (n == 3) ? 2'h2 : n[1:0], 5'h1F - n[4:0]};
      apb(1'b1, SIDX[n], {24'h0, v});
      apb(1'b0, SIDX[n], 32'h0);
      `CHK("sens_rw", {24'h0, v}, rd)
    end
    `CHK("no_early", {2'h1, 8'h04}, chan_cfg[2])
    pulse(4'h4);
    `CHK("ch2_win", {2'h2, 8'h5D}, chan_cfg[2])
    `CHK("two_ch2", {2'h1, 8'h04}, chan_cfg2[2])
    `CHK("ch0_hold", {2'h1, 8'h04}, chan_cfg[0])
    pulse(4'hB);
    for (int n = 0; n < 4; n++)
    begin
      v = {n[0], (n == 3) ? 2'h2 : n[1:0], 5'h1F - n[4:0]};
      `CHK("cfg_win", {n[1:0], v}, chan_cfg[n])
    end
    `CHK("two_ch1", {2'h1, 8'hBE}, chan_cfg2[1])
    `CHK("two_ch3", {2'h1, 8'h04}, chan_cfg2[3])
    // software keeps the reserved tracking bits at zero
    apb(1'b1, scc_pkg::IDX_CH0_TRACKING, 32'h00000006);
    apb(1'b0, scc_pkg::IDX_CH0_TRACKING, 32'h0);
    `CHK("trk_rw", 32'h00000006, rd)
    `CHK("ftf_out", 2'h3, ftf)
    apb(1'b1, scc_pkg::IDX_CH0_TRACKING, 32'h00000000);
    #1;
    `CHK("ftf_lag", 2'h3, ftf)
    @(posedge pclk);
    #1;
    `CHK("ftf_zero", 2'h0, ftf)
    apb(1'b1, 8'h21, 32'h000000FF);
    `CHK("bad_werr", 1'b1, err)
    apb(1'b0, 8'h21, 32'h0);
    `CHK("bad_rerr", 1'b1, err)
    `CHK("bad_rd", 32'h0, rd)
    apb(1'b0, scc_pkg::IDX_CH0_SENSOR, 32'h0);
    `CHK("ok_err", 1'b0, err)
    `CHK("untouched", 32'h0000001F, rd)
    apb(1'b1, scc_pkg::IDX_WINDOW_CTRL, 32'h00000005);
    apb(1'b0, scc_pkg::IDX_WINDOW_CTRL, 32'h0);
    `CHK("win_rw", 32'h00000005, rd)
    `CHK("div_out", 3'h5, div_exp)
    apb(1'b0, scc_pkg::IDX_ACTIVE_STATUS, 32'h0);
    `CHK("status", 32'h0000000F, rd)
    wrap_up();
  end
endmodule // scc_regs_test
